/* rtl/tuner_serial_pkg.sv */
package tuner_serial_pkg;
    // bus address: fixed one and the three strap-selected ones (7-bit)
    localparam logic [6:0] ADDR_FIXED = 7'h61;
    localparam logic [6:0] ADDR_SEL_LOW = 7'h60;
    localparam logic [6:0] ADDR_SEL_MID = 7'h62;
    localparam logic [6:0] ADDR_SEL_HIGH = 7'h63;
    // decoded analog pin levels
    localparam logic [1:0] LEVEL_LOW = 2'h0;
    localparam logic [1:0] LEVEL_MID = 2'h1;
    localparam logic [1:0] LEVEL_HIGH = 2'h2;
    // reference divider ratios
    localparam logic [10:0] REF_RATIO_512 = 11'h200;
    localparam logic [10:0] REF_RATIO_640 = 11'h280;
    localparam logic [10:0] REF_RATIO_1024 = 11'h400;
    // byte layout
    localparam int BYTE_BITS = 8;
    localparam int CTRL_MARK_BIT = 7;
    localparam int CB_PUMP_HIGH = 6;
    localparam int CB_DIV_TEST = 5;
    localparam int CB_PUMP_OFF = 4;
    localparam int CB_PRESCALER = 3;
    localparam int CB_RATIO_B = 2;
    localparam int CB_RATIO_A = 1;
    localparam int CB_DRIVE_OFF = 0;
    localparam int PORT_BYTE_LSB = 4;
    // three-wire word: divider bits then port bits
    localparam int WORD_BITS = 18;
    localparam int WORD_DIV_BITS = 14;
    // reset values
    localparam logic [14:0] DIVIDER_RESET = 15'h0000;
    localparam logic [7:0] CONTROL_RESET = 8'h88;
    localparam logic [3:0] PORTS_RESET = 4'h0;
    localparam logic POWER_LOSS_RESET = 1'b1;
endpackage : tuner_serial_pkg

/* rtl/tuner_pll_serial_control.sv */
`timescale 1ns/1ps
module tuner_pll_serial_control
    import tuner_serial_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // serial bus pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_select_enable_pin,
    input wire logic [1:0] addr_select_level,
    input wire logic [1:0] ref_ratio_select_level,
    // port pins, open collector
    input wire logic port_seven_level,
    input wire logic port_four_level,
    input wire logic port_five_level,
    output logic port_four_oe,
    output logic port_five_oe,
    output logic port_seven_oe,
    output logic multi_pin_oe,
    // analog side results
    input wire logic loop_locked,
    input wire logic supply_low,
    input wire logic [2:0] conv_code,
    // synthesizer settings
    output logic [14:0] divider_ratio,
    output logic [10:0] ref_ratio,
    output logic pump_current_high,
    output logic divider_test_enable,
    output logic pump_disable,
    output logic prescaler_on,
    output logic tuning_drive_disable,
    output logic pll_disable,
    output logic three_wire_mode,
    output logic power_loss
);
    import tuner_serial_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // input synchronisers with agreement filter
    localparam int NSYNC = 15;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] filt_q;

    assign raw = {scl, sda_in, addr_select_enable_pin, port_seven_level,
                  port_four_level, port_five_level, loop_locked,
                  supply_low, conv_code, addr_select_level,
                  ref_ratio_select_level};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            logic [2:0] s_q;
            // first stage feeds only the second stage
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    s_q <= 3'h0;
                end else begin
                    s_q <= {s_q[1:0], raw[gi]};
                end
            end
            // change counts once stages two and three agree
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    filt_q[gi] <= 1'b0;
                end else if (s_q[1] == s_q[2]) begin
                    filt_q[gi] <= s_q[2];
                end
            end
        end
    endgenerate

    logic scl_f, sda_f, ena_f, p7_f, p4_f, p5_f, lock_f, sup_low_f;
    logic [2:0] conv_f;
    logic [1:0] as_lvl_f, rds_lvl_f;
    assign {scl_f, sda_f, ena_f, p7_f, p4_f, p5_f, lock_f, sup_low_f,
            conv_f, as_lvl_f, rds_lvl_f} = filt_q;

    ////////////////////////////////////////////////////////////////////
    // edge detection on filtered lines
    logic scl_d_q, sda_d_q, ena_d_q;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
            ena_d_q <= 1'b0;
        end else begin
            scl_d_q <= scl_f;
            sda_d_q <= sda_f;
            ena_d_q <= ena_f;
        end
    end

    logic scl_rise, scl_fall, ena_rise, ena_fall, start_c, stop_c;
    logic tw_active, three_wire_q, power_loss_q;
    assign scl_rise = scl_f && !scl_d_q;
    assign scl_fall = !scl_f && scl_d_q;
    assign ena_rise = ena_f && !ena_d_q;
    assign ena_fall = !ena_f && ena_d_q;
    // a three-wire frame may wiggle data with clock high; not a start
    assign tw_active = three_wire_q && ena_f;
    assign start_c = scl_f && scl_d_q && !sda_f && sda_d_q && !tw_active;
    assign stop_c = scl_f && scl_d_q && sda_f && !sda_d_q && !tw_active;

    ////////////////////////////////////////////////////////////////////
    // two-wire slave state machine
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK,
        ST_RD_BYTE, ST_RD_ACK
    } bus_state_e;

    bus_state_e state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] status_q;
    logic read_dir_q;
    logic read_seq_q;
    logic host_ack_q;
    logic sda_oe_q;
    logic expect_low_q;
    logic expect_port_q;
    logic addr_hit;
    logic [6:0] sel_addr;
    logic [7:0] status_now;

    // strap-selected address from the decoded pin level
    always_comb begin
        unique case (as_lvl_f)
            LEVEL_LOW: sel_addr = ADDR_SEL_LOW;
            LEVEL_MID: sel_addr = ADDR_SEL_MID;
            default: sel_addr = ADDR_SEL_HIGH;
        endcase
    end
    assign addr_hit = (shift_q[7:1] == ADDR_FIXED) ||
                      (shift_q[7:1] == sel_addr);

    // live status: flag, lock, port levels, converter code
    assign status_now = {power_loss_q, lock_f, p7_f, p4_f, p5_f,
                         conv_f};

    logic wr_byte_done;
    assign wr_byte_done = (state_q == ST_WR_BYTE) && scl_fall &&
                          (bit_cnt_q == 4'(BYTE_BITS));

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            status_q <= 8'h00;
            read_dir_q <= 1'b0;
            host_ack_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (start_c) begin
            state_q <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (stop_c) begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                ST_ADDR, ST_WR_BYTE: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_f};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'(BYTE_BITS)) begin
                        if (state_q == ST_WR_BYTE) begin
                            state_q <= ST_WR_ACK;
                            sda_oe_q <= 1'b1;
                        end else if (addr_hit) begin
                            state_q <= ST_ADDR_ACK;
                            read_dir_q <= shift_q[0];
                            sda_oe_q <= 1'b1;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_WR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        if (state_q == ST_ADDR_ACK && read_dir_q) begin
                            // bits change only on falling clock
                            state_q <= ST_RD_BYTE;
                            status_q <= status_now;
                            sda_oe_q <= !status_now[7];
                        end else begin
                            state_q <= ST_WR_BYTE;
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
                ST_RD_BYTE: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_q == 4'(BYTE_BITS)) begin
                            state_q <= ST_RD_ACK;
                            sda_oe_q <= 1'b0;
                        end else begin
                            status_q <= {status_q[6:0], 1'b0};
                            sda_oe_q <= !status_q[6];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        host_ack_q <= !sda_f;
                    end else if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        if (host_ack_q) begin
                            state_q <= ST_RD_BYTE;
                            status_q <= status_now;
                            sda_oe_q <= !status_now[7];
                        end else begin
                            // line left free so the host can stop
                            state_q <= ST_IDLE;
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // a read sequence is open from an accepted read address to the next start or stop
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            read_seq_q <= 1'b0;
        end else if (start_c || stop_c) begin
            read_seq_q <= 1'b0;
        end else if (state_q == ST_ADDR_ACK && read_dir_q) begin
            read_seq_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power-loss flag; a new loss wins over the clearing stop
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            power_loss_q <= POWER_LOSS_RESET;
        end else if (sup_low_f) begin
            power_loss_q <= 1'b1;
        end else if (stop_c && read_seq_q) begin
            power_loss_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write byte routing: first bit picks divider or control pair
    logic [6:0] div_high_q;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            expect_low_q <= 1'b0;
            expect_port_q <= 1'b0;
            div_high_q <= 7'h00;
        end else if (state_q == ST_ADDR_ACK) begin
            expect_low_q <= 1'b0;
            expect_port_q <= 1'b0;
        end else if (wr_byte_done) begin
            if (expect_low_q) begin
                expect_low_q <= 1'b0;
            end else if (expect_port_q) begin
                expect_port_q <= 1'b0;
            end else if (shift_q[CTRL_MARK_BIT]) begin
                expect_port_q <= 1'b1;
            end else begin
                expect_low_q <= 1'b1;
                div_high_q <= shift_q[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // three-wire receiver and mode detection
    logic [WORD_BITS-1:0] word_q;
    logic [4:0] pulse_cnt_q;
    logic word_ok;
    assign word_ok = ena_fall && (pulse_cnt_q == 5'(WORD_BITS));

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            word_q <= '0;
            pulse_cnt_q <= 5'h0;
        end else if (ena_rise) begin
            pulse_cnt_q <= 5'h0;
        end else if (ena_f && scl_fall) begin
            // low-enable clocks never reach here
            word_q <= {word_q[WORD_BITS-2:0], sda_f};
            if (pulse_cnt_q != 5'h1f) begin
                pulse_cnt_q <= pulse_cnt_q + 5'h1;
            end
        end
    end

    // an enable pulse framing exactly 18 clocks means three-wire; an address hit
    // on the two-wire bus switches back
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            three_wire_q <= 1'b0;
        end else if (state_q == ST_ADDR_ACK) begin
            three_wire_q <= 1'b0;
        end else if (word_ok) begin
            three_wire_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // programmed settings; lost while the filtered supply-low input is high
    logic [14:0] divider_q;
    logic [7:0] control_q;
    logic [3:0] ports_q;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            divider_q <= DIVIDER_RESET;
            control_q <= CONTROL_RESET;
            ports_q <= PORTS_RESET;
        end else if (sup_low_f) begin
            divider_q <= DIVIDER_RESET;
            control_q <= CONTROL_RESET;
            ports_q <= PORTS_RESET;
        end else if (word_ok) begin
            // top divider bit forced to zero
            divider_q <= {1'b0, word_q[WORD_BITS-1 -: WORD_DIV_BITS]};
            ports_q <= word_q[3:0];
        end else if (wr_byte_done) begin
            if (expect_low_q) begin
                divider_q <= {div_high_q, shift_q};
            end else if (expect_port_q) begin
                ports_q <= shift_q[7:PORT_BYTE_LSB];
            end else if (shift_q[CTRL_MARK_BIT]) begin
                control_q <= shift_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // effective settings
    logic [10:0] ratio_i2c, ratio_tw;
    always_comb begin
        if (!control_q[CB_RATIO_A]) begin
            ratio_i2c = REF_RATIO_640;
        end else if (control_q[CB_RATIO_B]) begin
            ratio_i2c = REF_RATIO_512;
        end else begin
            ratio_i2c = REF_RATIO_1024;
        end
        unique case (rds_lvl_f)
            LEVEL_LOW: ratio_tw = REF_RATIO_1024;
            LEVEL_MID: ratio_tw = REF_RATIO_512;
            default: ratio_tw = REF_RATIO_640;
        endcase
    end

    // three-wire overrides the control byte
    assign pump_current_high = three_wire_q | control_q[CB_PUMP_HIGH];
    assign divider_test_enable = !three_wire_q && control_q[CB_DIV_TEST];
    assign pump_disable = !three_wire_q && control_q[CB_PUMP_OFF];
    assign prescaler_on = three_wire_q | control_q[CB_PRESCALER];
    assign tuning_drive_disable = !three_wire_q &&
                                  control_q[CB_DRIVE_OFF];
    assign ref_ratio = three_wire_q ? ratio_tw : ratio_i2c;
    assign divider_ratio = divider_q;
    assign pll_disable = (divider_q == DIVIDER_RESET);
    assign three_wire_mode = three_wire_q;
    assign power_loss = power_loss_q;

    // ports float while power is in doubt; multi pin is lock in 3-wire
    assign port_seven_oe = ports_q[3] && !power_loss_q;
    assign port_five_oe = ports_q[1] && !power_loss_q;
    assign port_four_oe = ports_q[0] && !power_loss_q;
    assign multi_pin_oe = three_wire_q ? lock_f
                          : (ports_q[2] && !power_loss_q);

    // open-drain data line: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_q;

endmodule : tuner_pll_serial_control

/* bench/tuner_pll_serial_control_sva.sv */
`timescale 1ns/1ps
module tuner_pll_serial_check (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // bus, strap and analog-side pins
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_oe,
    input wire logic addr_select_enable_pin,
    input wire logic [1:0] ref_ratio_select_level,
    input wire logic loop_locked,
    input wire logic supply_low,
    // port drivers and settings
    input wire logic port_four_oe,
    input wire logic port_five_oe,
    input wire logic port_seven_oe,
    input wire logic multi_pin_oe,
    input wire logic [14:0] divider_ratio,
    input wire logic [10:0] ref_ratio,
    input wire logic pump_current_high,
    input wire logic divider_test_enable,
    input wire logic pump_disable,
    input wire logic prescaler_on,
    input wire logic tuning_drive_disable,
    input wire logic pll_disable,
    input wire logic three_wire_mode,
    input wire logic power_loss
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    // ratio picked by the select pin level; codes 2 and 3 both mean high
    function automatic logic [10:0] ratio_of(input logic [1:0] lvl);
        return lvl == 2'h0 ? 11'h400 : (lvl == 2'h1 ? 11'h200 : 11'h280);
    endfunction : ratio_of

    ////////////////////////////////////////
    // power flag and port safety
    power_up_a: assert property (
        $rose(arst_n) |-> power_loss && divider_ratio == 15'h0000)
        else $error("power-up state wrong");
    supply_drop_a: assert property (
        $rose(supply_low) |-> ##[1:6] power_loss)
        else $error("flag not set on supply drop");
    ports_off_a: assert property (
        power_loss |-> !(port_four_oe || port_five_oe || port_seven_oe))
        else $error("port on during power loss");
    stop_clear_a: assert property (
        $fell(power_loss) |-> scl && sda_in && $past(scl, 6))
        else $error("flag cleared outside a stop");
    // the data bit must not move once the clock has been high a while
    bit_stable_a: assert property (
        scl [*4] |-> $stable(sda_oe))
        else $error("data moved while clock high");
    pll_off_a: assert property (
        pll_disable == (divider_ratio == 15'h0000))
        else $error("pll disable wrong");

    ////////////////////////////////////////
    // three-wire mode
    top_bit_a: assert property (
        three_wire_mode |-> !divider_ratio[14])
        else $error("divider msb set in three-wire");
    forced_ctrl_a: assert property (
        three_wire_mode |-> pump_current_high && !divider_test_enable &&
            !pump_disable && prescaler_on && !tuning_drive_disable)
        else $error("control not forced");
    ratio_pick_a: assert property (
        (three_wire_mode && $stable(ref_ratio_select_level)) [*6] |->
            ref_ratio == ratio_of(ref_ratio_select_level))
        else $error("reference ratio wrong");
    lock_pin_a: assert property (
        (three_wire_mode && $stable(loop_locked)) [*6] |->
            multi_pin_oe == loop_locked)
        else $error("lock output wrong");
    mode_entry_a: assert property (
        $rose(three_wire_mode) |->
            !addr_select_enable_pin && $past(addr_select_enable_pin, 8))
        else $error("word taken outside enable fall");
endmodule : tuner_pll_serial_check

/* bench/tuner_host_model.sv */
`timescale 1ns/1ps
module tuner_host_model (
    // lines driven by the host
    output logic scl,
    output logic sda_pull,
    output logic enable,
    // resolved data line
    input wire logic sda_line
);
    localparam realtime H = 62.5;

    // bus idles high and released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        enable = 1'b0;
    end

    ////////////////////////////////////////
    // data only moves mid-way through clock low, never near an edge
    task automatic put(input logic b);
        #(H / 2) sda_pull = !b;
        #(H / 2) scl = 1'b1;
        #H scl = 1'b0;
    endtask : put
    // sampled late in the high phase, far from the device's drive update
    task automatic get(output logic v);
        #(H / 2) sda_pull = 1'b0;
        #(H / 2) scl = 1'b1;
        #(H - 5) v = sda_line;
        #5 scl = 1'b0;
    endtask : get
    task automatic start;
        #H sda_pull = 1'b1;
        #H scl = 1'b0;
    endtask : start
    task automatic stop;
        #(H / 2) sda_pull = 1'b1;
        #(H / 2) scl = 1'b1;
        #H sda_pull = 1'b0;
        #H;
    endtask : stop
    task automatic wr(input logic [7:0] d, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) put(d[i]);
        get(v);
        ack = !v;
    endtask : wr
    // low in the ack slot asks for one more status byte
    task automatic rd(input logic more, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get(d[i]);
        put(!more);
    endtask : rd
    // pulses with enable low first, which the device must not count
    task automatic tw(input logic [17:0] w, input int n);
        repeat (3) begin
            #H scl = 1'b1;
            #H scl = 1'b0;
        end
        #H enable = 1'b1;
        for (int i = 17; i > 17 - n; i--) put(w[i]);
        #(2 * H) enable = 1'b0;
        #H sda_pull = 1'b0;
        #H scl = 1'b1;
        #H;
    endtask : tw
endmodule : tuner_host_model

/* bench/tuner_pll_serial_control_bench.sv */
`timescale 1ns/1ps
module tuner_pll_serial_control_bench;
    import tuner_serial_pkg::*;
    // stimulus, outputs and bookkeeping
    logic sys_clk, arst_n, scl, sda_pull, enable, supply_low, loop_locked;
    logic [2:0] conv_code, ext;
    logic [1:0] addr_select_level, ref_ratio_select_level;
    logic sda_out, sda_oe, port_four_oe, port_five_oe, port_seven_oe;
    logic multi_pin_oe, pump_current_high, divider_test_enable;
    logic pump_disable, prescaler_on, tuning_drive_disable, pll_disable;
    logic three_wire_mode, power_loss, pl_exp;
    logic [14:0] divider_ratio;
    logic [10:0] ref_ratio;
    logic [17:0] w;
    logic [7:0] straps [5] = '{8'hc1, 8'hc5, 8'hc7, 8'hc3, 8'hc3};
    logic [13:0] tw_div [3] = '{14'h3fff, 14'h0155, 14'h2abc};
    logic [10:0] ratio_exp [3] = '{11'h400, 11'h200, 11'h280};
    int n_fail = 0;
    int num_checks = 0;
    wire sda_line, p7_lvl, p4_lvl, p5_lvl;

    // wired-and data line, open-collector ports read low while on
    assign sda_line = !(sda_oe && !sda_out) && !sda_pull;
    assign p7_lvl = ext[2] && !port_seven_oe;
    assign p4_lvl = ext[1] && !port_four_oe;
    assign p5_lvl = ext[0] && !port_five_oe;

    tuner_pll_serial_control u_tuner_pll_serial_control (
        .sys_clk(sys_clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_select_enable_pin(enable),
        .addr_select_level(addr_select_level),
        .ref_ratio_select_level(ref_ratio_select_level),
        .port_seven_level(p7_lvl), .port_four_level(p4_lvl),
        .port_five_level(p5_lvl), .port_four_oe(port_four_oe),
        .port_five_oe(port_five_oe), .port_seven_oe(port_seven_oe),
        .multi_pin_oe(multi_pin_oe), .loop_locked(loop_locked),
        .supply_low(supply_low), .conv_code(conv_code),
        .divider_ratio(divider_ratio), .ref_ratio(ref_ratio),
        .pump_current_high(pump_current_high),
        .divider_test_enable(divider_test_enable),
        .pump_disable(pump_disable), .prescaler_on(prescaler_on),
        .tuning_drive_disable(tuning_drive_disable),
        .pll_disable(pll_disable), .three_wire_mode(three_wire_mode),
        .power_loss(power_loss));
    tuner_host_model u_tuner_host_model (.scl(scl), .sda_pull(sda_pull),
        .enable(enable), .sda_line(sda_line));

    ////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // watchdog well beyond the roughly fifty microseconds of traffic
    initial begin
        #500000;
        n_fail++;
        test_done();
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    task automatic settle;
        repeat (12) @(negedge sys_clk);
    endtask : settle
    // read n status bytes, last one refused, then stop
    task automatic read_seq(input logic [7:0] a, input int n);
        logic ack;
        logic [7:0] d;
        u_tuner_host_model.start();
        u_tuner_host_model.wr(a, ack);
        chk(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_tuner_host_model.rd(i < n - 1, d);
            chk(d, {pl_exp, loop_locked, ext, conv_code});
        end
        settle();
        chk(sda_oe, 1'b0);
        u_tuner_host_model.stop();
        settle();
    endtask : read_seq
    task automatic write_seq(input logic [7:0] a, input logic [31:0] b,
                             input int n, input logic ok);
        logic ack;
        u_tuner_host_model.start();
        u_tuner_host_model.wr(a, ack);
        chk(ack, ok);
        for (int i = 0; i < n && ok; i++) begin
            u_tuner_host_model.wr(b[31 - 8 * i -: 8], ack);
            chk(ack, 1'b1);
        end
        u_tuner_host_model.stop();
        settle();
    endtask : write_seq

    ////////////////////////////////////////
    initial begin
        arst_n = 1'b0;
        supply_low = 1'b0;
        loop_locked = 1'b0;
        conv_code = 3'h0;
        ext = 3'h7;
        addr_select_level = LEVEL_MID;
        ref_ratio_select_level = LEVEL_LOW;
        pl_exp = 1'b1;
        repeat (10) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (20) @(negedge sys_clk);
        chk({power_loss, pll_disable, port_seven_oe}, 3'b110);
        read_seq(8'hc3, 2);
        chk(power_loss, 1'b0);
        pl_exp = 1'b0;
        // converter codes 0 to 4, strap addresses, ports left off as inputs
        for (int i = 0; i < 5; i++) begin
            conv_code = i[2:0];
            loop_locked = i[0];
            ext = i[2:0] + 3'h3;
            addr_select_level = i[1:0];
            read_seq(straps[i], 1);
        end
        addr_select_level = LEVEL_LOW;
        write_seq(8'hc4, 32'h0, 0, 1'b0);
        write_seq(8'hc2, 32'h1234da00, 3, 1'b1);
        chk(divider_ratio, 15'h1234);
        chk({pll_disable, pump_current_high, divider_test_enable,
             pump_disable, prescaler_on, tuning_drive_disable},
            6'b010110);
        chk(ref_ratio, 11'h400);
        write_seq(8'hc2, 32'h89b00000, 4, 1'b1);
        chk({pll_disable, tuning_drive_disable, port_seven_oe,
             port_five_oe, port_four_oe, multi_pin_oe}, 6'b111110);
        chk(ref_ratio, 11'h280);
        // supply drop wipes settings and turns ports off
        supply_low = 1'b1;
        settle();
        supply_low = 1'b0;
        settle();
        pl_exp = 1'b1;
        chk({power_loss, port_seven_oe, port_five_oe, port_four_oe,
             pll_disable}, 5'b10001);
        read_seq(8'hc3, 1);
        pl_exp = 1'b0;
        // three-wire words under each reference select level
        for (int r = 0; r < 3; r++) begin
            ref_ratio_select_level = r[1:0];
            loop_locked = r[0];
            w = {tw_div[r], 4'ha};
            u_tuner_host_model.tw(w, 18);
            settle();
            chk(divider_ratio, {1'b0, w[17:4]});
            chk({three_wire_mode, port_seven_oe, port_five_oe, port_four_oe,
                 multi_pin_oe}, {4'b1110, loop_locked});
            chk(ref_ratio, ratio_exp[r]);
            chk({pump_current_high, divider_test_enable, pump_disable,
                 prescaler_on, tuning_drive_disable}, 5'b10010);
        end
        u_tuner_host_model.tw(18'h00010, 17);
        settle();
        chk(divider_ratio, {1'b0, 14'h2abc});
        ext = 3'h0;
        read_seq(8'hc3, 1);
        chk(three_wire_mode, 1'b0);
        test_done();
    end
endmodule : tuner_pll_serial_control_bench

bind tuner_pll_serial_control tuner_pll_serial_check u_chk (
    .sys_clk(sys_clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_in),
    .sda_oe(sda_oe), .addr_select_enable_pin(addr_select_enable_pin),
    .ref_ratio_select_level(ref_ratio_select_level),
    .loop_locked(loop_locked), .supply_low(supply_low),
    .port_four_oe(port_four_oe), .port_five_oe(port_five_oe),
    .port_seven_oe(port_seven_oe), .multi_pin_oe(multi_pin_oe),
    .divider_ratio(divider_ratio), .ref_ratio(ref_ratio),
    .pump_current_high(pump_current_high),
    .divider_test_enable(divider_test_enable),
    .pump_disable(pump_disable), .prescaler_on(prescaler_on),
    .tuning_drive_disable(tuning_drive_disable),
    .pll_disable(pll_disable), .three_wire_mode(three_wire_mode),
    .power_loss(power_loss));
